// *** crctl_pkg.sv ***
// crctl_pkg.sv: constants shared by the cold redundancy controller files
// assumes a 100 MHz clock and a 32-bit AXI4-Lite register port
`default_nettype none

package crctl_pkg;

   // ************************************************************
   // register bus
   // ************************************************************
   localparam int AXI_AW = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] OFS_ROLE = 8'h00;
   localparam logic [7:0] OFS_POS1 = 8'h04;
   localparam logic [7:0] OFS_POS2 = 8'h08;
   localparam logic [7:0] OFS_POS3 = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // ************************************************************
   // role codes
   // ************************************************************
   localparam int ROLE_W = 8;
   localparam logic [ROLE_W-1:0] ROLE_STD = 8'h00;
   localparam logic [ROLE_W-1:0] ROLE_ACTIVE = 8'h01;
   localparam logic [ROLE_W-1:0] ROLE_SB1 = 8'h02;
   localparam logic [ROLE_W-1:0] ROLE_SB3 = 8'h04;
   localparam logic [ROLE_W-1:0] ROLE_ALWAYS = 8'h05;
   localparam logic [ROLE_W-1:0] ROLE_RST = ROLE_STD;

   // ************************************************************
   // fields
   // ************************************************************
   localparam int LEVEL_W = 12;
   localparam int NUM_POS = 3;
   localparam int FLD_EN_LSB = 0;
   localparam int FLD_DIS_LSB = 16;
   localparam int ST_CONV_ON = 0;
   localparam int ST_WAKE = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_ABOVE = 3;
   localparam int ST_STANDBY = 4;
   localparam int ST_REVERTED = 5;

   // ************************************************************
   // load share scale and threshold reset values
   // ************************************************************
   localparam int LS_FULL_MV = 8000;
   localparam int LS_FULL_CODE = 4000;

   function automatic logic [LEVEL_W-1:0] mvToCode(input int mv);
      return LEVEL_W'(mv * LS_FULL_CODE / LS_FULL_MV);
   endfunction

   localparam logic [LEVEL_W-1:0] EN_RST [NUM_POS] = '{mvToCode(3200), mvToCode(5000), mvToCode(6700)};
   localparam logic [LEVEL_W-1:0] DIS_RST [NUM_POS] = '{mvToCode(1440), mvToCode(3010), mvToCode(4520)};

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int WAKE_RESP_US = 100;
   localparam int WAKE_RESP_CYC = WAKE_RESP_US * 1000 / CLK_PERIOD_NS;

endpackage

`default_nettype wire

// *** crctl_share_if.sv ***
// crctl_share_if.sv: load share comparison signals between controller and comparator
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface crctl_share_if
   import crctl_pkg::*;
   ();
   logic [LEVEL_W-1:0] level;
   logic [LEVEL_W-1:0] enLevel;
   logic [LEVEL_W-1:0] disLevel;
   logic restart;
   logic wantOn;

   modport ctrl (output level, output enLevel, output disLevel, output restart, input wantOn);
   modport cmp (input level, input enLevel, input disLevel, input restart, output wantOn);
endinterface

`default_nettype wire

// *** crctl_wake_sync.sv ***
// crctl_wake_sync.sv: two-stage synchroniser and falling edge detect for the wake line
// assumes the wake line idles high
`timescale 1ns/1ps
`default_nettype none

module crctl_wake_sync
   import crctl_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic wakeIn,
   output logic wakeSync,
   output logic wakeFall
);
   logic sync1_r, sync1_nxt;
   logic sync2_r, sync2_nxt;
   logic prev_r, prev_nxt;

   always_comb
   begin
      sync1_nxt = wakeIn;
      sync2_nxt = sync1_r;
      prev_nxt = sync2_r;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         prev_r <= 1'b1;
      end
      else
      begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign wakeSync = sync2_r;
   assign wakeFall = prev_r & ~sync2_r;
endmodule

`default_nettype wire

// *** crctl_share_cmp.sv ***
// crctl_share_cmp.sv: load share comparator with enable/disable hysteresis
// assumes the level input is synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module crctl_share_cmp
   import crctl_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   crctl_share_if.cmp shr
);
   typedef enum {CMP_OFF, CMP_ON} crctl_cmp_t;
   crctl_cmp_t state_r, state_nxt;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         CMP_OFF:
         begin
            if (shr.level >= shr.enLevel)
               state_nxt = CMP_ON;
         end
         CMP_ON:
         begin
            if (shr.level < shr.disLevel)
               state_nxt = CMP_OFF;
         end
         default:
            state_nxt = CMP_OFF;
      endcase
      if (shr.restart)
         state_nxt = CMP_OFF;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         state_r <= CMP_OFF;
      else
         state_r <= state_nxt;
   end

   assign shr.wantOn = (state_r == CMP_ON);
endmodule

`default_nettype wire

// *** crctl_cold_redundancy.sv ***
// crctl_cold_redundancy.sv: per-supply cold redundancy controller with AXI4-Lite registers
// assumes load share level, fault inputs and the wake line are sampled on clk;
// the shared wake line pin is resolved outside from wakeLineOut and wakeLineOe
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - fault or undervoltage pulls wake line low
// - standby supply runs while wake line low
// - no active driver means every supply runs
// - converter on after reset, before programming
// - standby 02h to 04h off only if wake high, load low
// - standby 02h to 04h watches load share level continuously
// - standard role always runs, wake tri-stated unless faulted
// - active role always runs, drives wake high unless faulted
// - standby one uses 3.2V on, 1.44V off
// - standby two uses 5.0V on, 3.01V off
// - standby three uses 6.7V on, 4.52V off
// - load share scales linearly, 8.0V full
// - thresholds are software programmable registers
// - role byte, codes 00h to 05h
// - wake falling edge reverts standby role to 00h
// - standby converter on within 100 us
module crctl_cold_redundancy
   import crctl_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wakeLineIn,
   output logic wakeLineOut,
   output logic wakeLineOe,
   input wire logic [LEVEL_W-1:0] loadShareLevel,
   input wire logic supplyFault,
   input wire logic outputUndervolt,
   output logic converterOnN
);
   typedef enum {SUP_ACTIVE, SUP_STANDBY} crctl_sup_t;

   // ************************************************************
   // declarations
   // ************************************************************
   logic awHeld_r, awHeld_nxt;
   logic [AXI_AW-1:0] awAddr_r, awAddr_nxt;
   logic wHeld_r, wHeld_nxt;
   logic [31:0] wData_r, wData_nxt;
   logic [3:0] wStrb_r, wStrb_nxt;
   logic awReady_r, awReady_nxt;
   logic wReady_r, wReady_nxt;
   logic bValid_r, bValid_nxt;
   logic [1:0] bResp_r, bResp_nxt;
   logic arReady_r, arReady_nxt;
   logic rValid_r, rValid_nxt;
   logic [31:0] rData_r, rData_nxt;
   logic [1:0] rResp_r, rResp_nxt;
   logic doWrite;

   logic [ROLE_W-1:0] role_r, role_nxt;
   logic [LEVEL_W-1:0] posEn_r [NUM_POS];
   logic [LEVEL_W-1:0] posEn_nxt [NUM_POS];
   logic [LEVEL_W-1:0] posDis_r [NUM_POS];
   logic [LEVEL_W-1:0] posDis_nxt [NUM_POS];
   logic reverted_r, reverted_nxt;

   crctl_sup_t supState_r, supState_nxt;
   logic convOnN_r, convOnN_nxt;
   logic wakeOut_r, wakeOut_nxt;
   logic wakeOe_r, wakeOe_nxt;

   logic wakeSync;
   logic wakeFall;
   logic faultReq;
   logic standbyRole;
   logic loadRole;
   logic [1:0] posSel;
   logic [31:0] statusWord;

   crctl_share_if shr ();

   function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = data[8*i +: 8];
      return res;
   endfunction

   function automatic logic [7:0] wordOfs(input logic [AXI_AW-1:0] addr);
      return {addr[7:2], 2'b00};
   endfunction

   function automatic logic isMapped(input logic [AXI_AW-1:0] addr);
      logic [7:0] ofs;
      ofs = wordOfs(addr);
      return (ofs == OFS_ROLE) || (ofs == OFS_POS1) || (ofs == OFS_POS2) || (ofs == OFS_POS3)
         || (ofs == OFS_STATUS);
   endfunction

   // ************************************************************
   // submodules
   // ************************************************************
   crctl_wake_sync u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .wakeIn(wakeLineIn),
      .wakeSync(wakeSync),
      .wakeFall(wakeFall)
   );

   crctl_share_cmp u_cmp (
      .clk(clk),
      .arst_n(arst_n),
      .shr(shr)
   );

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   assign doWrite = awHeld_r & wHeld_r & ~bValid_r;

   always_comb
   begin
      awHeld_nxt = awHeld_r;
      awAddr_nxt = awAddr_r;
      wHeld_nxt = wHeld_r;
      wData_nxt = wData_r;
      wStrb_nxt = wStrb_r;
      bValid_nxt = bValid_r;
      bResp_nxt = bResp_r;
      rValid_nxt = rValid_r;
      rData_nxt = rData_r;
      rResp_nxt = rResp_r;
      if (s_axi_awvalid && awReady_r)
      begin
         awHeld_nxt = 1'b1;
         awAddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_r)
      begin
         wHeld_nxt = 1'b1;
         wData_nxt = s_axi_wdata;
         wStrb_nxt = s_axi_wstrb;
      end
      if (bValid_r && s_axi_bready)
         bValid_nxt = 1'b0;
      if (doWrite)
      begin
         awHeld_nxt = 1'b0;
         wHeld_nxt = 1'b0;
         bValid_nxt = 1'b1;
         bResp_nxt = isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rValid_r && s_axi_rready)
         rValid_nxt = 1'b0;
      if (s_axi_arvalid && arReady_r)
      begin
         rValid_nxt = 1'b1;
         rResp_nxt = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (wordOfs(s_axi_araddr))
            OFS_ROLE: rData_nxt = {24'h00_0000, role_r};
            OFS_POS1: rData_nxt = 32'((posDis_r[0] << FLD_DIS_LSB) | (posEn_r[0] << FLD_EN_LSB));
            OFS_POS2: rData_nxt = 32'((posDis_r[1] << FLD_DIS_LSB) | (posEn_r[1] << FLD_EN_LSB));
            OFS_POS3: rData_nxt = 32'((posDis_r[2] << FLD_DIS_LSB) | (posEn_r[2] << FLD_EN_LSB));
            OFS_STATUS: rData_nxt = statusWord;
            default: rData_nxt = 32'h0000_0000;
         endcase
      end
      awReady_nxt = ~awHeld_nxt;
      wReady_nxt = ~wHeld_nxt;
      arReady_nxt = ~rValid_nxt;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         awHeld_r <= 1'b0;
         awAddr_r <= '0;
         wHeld_r <= 1'b0;
         wData_r <= 32'h0000_0000;
         wStrb_r <= 4'h0;
         awReady_r <= 1'b0;
         wReady_r <= 1'b0;
         bValid_r <= 1'b0;
         bResp_r <= RESP_OKAY;
         arReady_r <= 1'b0;
         rValid_r <= 1'b0;
         rData_r <= 32'h0000_0000;
         rResp_r <= RESP_OKAY;
      end
      else
      begin
         awHeld_r <= awHeld_nxt;
         awAddr_r <= awAddr_nxt;
         wHeld_r <= wHeld_nxt;
         wData_r <= wData_nxt;
         wStrb_r <= wStrb_nxt;
         awReady_r <= awReady_nxt;
         wReady_r <= wReady_nxt;
         bValid_r <= bValid_nxt;
         bResp_r <= bResp_nxt;
         arReady_r <= arReady_nxt;
         rValid_r <= rValid_nxt;
         rData_r <= rData_nxt;
         rResp_r <= rResp_nxt;
      end
   end

   // ************************************************************
   // role, thresholds, status
   // ************************************************************
   assign standbyRole = (role_r >= ROLE_SB1) && (role_r <= ROLE_ALWAYS);
   assign loadRole = (role_r >= ROLE_SB1) && (role_r <= ROLE_SB3);
   assign posSel = loadRole ? 2'(role_r - ROLE_SB1) : 2'h0;
   assign faultReq = supplyFault | outputUndervolt;

   always_comb
   begin
      statusWord = 32'h0000_0000;
      statusWord[ST_CONV_ON] = ~convOnN_r;
      statusWord[ST_WAKE] = wakeSync;
      statusWord[ST_FAULT] = faultReq;
      statusWord[ST_ABOVE] = shr.wantOn;
      statusWord[ST_STANDBY] = (supState_r == SUP_STANDBY);
      statusWord[ST_REVERTED] = reverted_r;
   end

   always_comb
   begin
      logic [31:0] merged;
      merged = 32'h0000_0000;
      role_nxt = role_r;
      reverted_nxt = reverted_r;
      posEn_nxt = posEn_r;
      posDis_nxt = posDis_r;
      if (doWrite)
      begin
         if (wordOfs(awAddr_r) == OFS_ROLE && wStrb_r[0] && wData_r[7:0] <= ROLE_ALWAYS)
            role_nxt = wData_r[7:0];
         for (int p = 0; p < NUM_POS; p++)
         begin
            if (wordOfs(awAddr_r) == 8'(OFS_POS1 + 8'(4 * p)))
            begin
               merged = strbMerge(32'((posDis_r[p] << FLD_DIS_LSB) | (posEn_r[p] << FLD_EN_LSB)),
                                  wData_r, wStrb_r);
               posEn_nxt[p] = merged[FLD_EN_LSB +: LEVEL_W];
               posDis_nxt[p] = merged[FLD_DIS_LSB +: LEVEL_W];
            end
         end
         if (wordOfs(awAddr_r) == OFS_STATUS && wStrb_r[0] && wData_r[ST_REVERTED])
            reverted_nxt = 1'b0;
      end
      if (wakeFall && standbyRole)
      begin
         role_nxt = ROLE_STD;
         reverted_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         role_r <= ROLE_RST;
         reverted_r <= 1'b0;
         posEn_r <= EN_RST;
         posDis_r <= DIS_RST;
      end
      else
      begin
         role_r <= role_nxt;
         reverted_r <= reverted_nxt;
         posEn_r <= posEn_nxt;
         posDis_r <= posDis_nxt;
      end
   end

   // ************************************************************
   // comparator feed
   // ************************************************************
   // position thresholds
   assign shr.level = loadShareLevel;
   assign shr.enLevel = posEn_r[posSel];
   assign shr.disLevel = posDis_r[posSel];
   assign shr.restart = ~loadRole | (role_nxt != role_r);

   // ************************************************************
   // converter and wake line
   // ************************************************************
   always_comb
   begin
      supState_nxt = SUP_ACTIVE;
      case (role_r)
         ROLE_STD, ROLE_ACTIVE:
            supState_nxt = SUP_ACTIVE;
         ROLE_ALWAYS:
            supState_nxt = wakeSync ? SUP_STANDBY : SUP_ACTIVE;
         default:
         begin
            if (loadRole && wakeSync && !shr.wantOn)
               supState_nxt = SUP_STANDBY;
            else
               supState_nxt = SUP_ACTIVE;
         end
      endcase
      convOnN_nxt = (supState_nxt == SUP_STANDBY);

      if (faultReq)
      begin
         wakeOe_nxt = 1'b1;
         wakeOut_nxt = 1'b0;
      end
      else if (role_r == ROLE_ACTIVE)
      begin
         wakeOe_nxt = 1'b1;
         wakeOut_nxt = 1'b1;
      end
      else
      begin
         wakeOe_nxt = 1'b0;
         wakeOut_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         supState_r <= SUP_ACTIVE;
         convOnN_r <= 1'b0;
         wakeOut_r <= 1'b0;
         wakeOe_r <= 1'b0;
      end
      else
      begin
         supState_r <= supState_nxt;
         convOnN_r <= convOnN_nxt;
         wakeOut_r <= wakeOut_nxt;
         wakeOe_r <= wakeOe_nxt;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign s_axi_awready = awReady_r;
   assign s_axi_wready = wReady_r;
   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp = bResp_r;
   assign s_axi_arready = arReady_r;
   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata = rData_r;
   assign s_axi_rresp = rResp_r;
   assign converterOnN = convOnN_r;
   assign wakeLineOut = wakeOut_r;
   assign wakeLineOe = wakeOe_r;
endmodule

`default_nettype wire

// *** crctl_cold_redundancy_chk.sv ***
// crctl_cold_redundancy_chk.sv: port checker for the cold redundancy controller
// assumes faults are held low during reset and the wake line is resolved outside
`timescale 1ns/1ps
`default_nettype none

module crctl_cold_redundancy_chk
   import crctl_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic wakeLineIn,
   input wire logic wakeLineOut,
   input wire logic wakeLineOe,
   input wire logic supplyFault,
   input wire logic outputUndervolt,
   input wire logic converterOnN
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   reset_conv_on_a: assert property (!$past(arst_n) |-> !converterOnN)
      else $error("converter off right after reset");
   fault_pull_a: assert property ((supplyFault || outputUndervolt) |=> wakeLineOe && !wakeLineOut)
      else $error("fault did not pull wake line low");
   high_drive_a: assert property (wakeLineOe && wakeLineOut |-> !$past(supplyFault) && !$past(outputUndervolt))
      else $error("wake line driven high during fault");
   low_drive_a: assert property (wakeLineOe && !wakeLineOut |-> $past(supplyFault) || $past(outputUndervolt))
      else $error("wake line driven low without fault");
   conv_off_a: assert property (converterOnN |-> $past(wakeLineIn, 3))
      else $error("converter off while wake line low");
   wake_resp_a: assert property ($fell(wakeLineIn) ##1 !wakeLineIn [*2] |=> !converterOnN)
      else $error("converter slow to start on wake");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");

   cover property (supplyFault ##1 wakeLineOe);
   cover property ($rose(converterOnN));
   cover property ($fell(wakeLineIn) ##3 !converterOnN);
endmodule

bind crctl_cold_redundancy crctl_cold_redundancy_chk crctl_cold_redundancy_chk_i (.clk, .arst_n, .s_axi_rdata,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .wakeLineIn, .wakeLineOut,
   .wakeLineOe, .supplyFault, .outputUndervolt, .converterOnN);

`default_nettype wire

// *** crctl_peer_model.sv ***
// crctl_peer_model.sv: another paralleled supply on the shared wake line
// assumes mode 0 released, 1 active healthy, 2 faulty
`timescale 1ns/1ps
`default_nettype none

module crctl_peer_model
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [1:0] peerMode,
   output logic peerOe,
   output logic peerOut
);
   // active peer holds line high, faulty peer low
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         peerOe <= 1'h0;
         peerOut <= 1'h1;
      end
      else
      begin
         peerOe <= peerMode != 2'h0;
         peerOut <= peerMode == 2'h1;
      end
   end
endmodule

`default_nettype wire

// *** testbench.sv ***
// testbench.sv: self-checking bench for the cold redundancy controller
// assumes one peer supply model; a wake line nobody drives reads low
`timescale 1ns/1ps
`default_nettype none

module testbench
   import crctl_pkg::*;
;
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic [AXI_AW-1:0] s_axi_awaddr = '0;
   logic [AXI_AW-1:0] s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0;
   logic s_axi_wvalid = 1'h0;
   logic s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0;
   logic [LEVEL_W-1:0] loadShareLevel = '0;
   logic supplyFault = 1'h0;
   logic outputUndervolt = 1'h0;
   logic [1:0] peerMode = 2'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] s_axi_rdata, d;
   logic wakeLineIn, wakeLineOut, wakeLineOe, converterOnN, peerOe, peerOut;
   int errors = 0;
   int checks = 0;
   int mRole = 0;
   int mAbove = 0;
   int mWake = 0;
   int mvEn [3] = '{3200, 5000, 6700};
   int mvDis [3] = '{1440, 3010, 4520};
   int mEn [3];
   int mDis [3];
   int lv [6];
   int v;

   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   assign wakeLineIn = !((wakeLineOe && !wakeLineOut) || (peerOe && !peerOut))
      && ((wakeLineOe && wakeLineOut) || (peerOe && peerOut));

   crctl_cold_redundancy crctl_cold_redundancy_i (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .wakeLineIn, .wakeLineOut, .wakeLineOe, .loadShareLevel, .supplyFault, .outputUndervolt, .converterOnN);
   crctl_peer_model crctl_peer_model_i (.clk, .arst_n, .peerMode, .peerOe, .peerOut);

   task automatic close_out();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic axiWr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      do
      begin
         @(posedge clk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
      end
      while (s_axi_awvalid || s_axi_wvalid);
      do @(posedge clk); while (!s_axi_bvalid);
      s_axi_bready <= 1'h1;
      @(posedge clk);
      chk("bresp", 32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'h0;
   endtask

   task automatic axiRd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge clk); while (!s_axi_rvalid);
      s_axi_rready <= 1'h1;
      @(posedge clk);
      d = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask

   task automatic rdChk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      axiRd(a);
      chk(n, d, e);
      chk("rresp", 32'(rr), 32'(er));
   endtask

   // model of wake line, role revert and hysteresis, compared after each change
   task automatic step(input string n);
      int e;
      repeat (5) @(posedge clk);
      e = !(supplyFault || outputUndervolt || peerMode == 2'h2) && (peerMode == 2'h1 || mRole == 1);
      if (mWake && !e && mRole >= 2)
         mRole = 0;
      mWake = e;
      if (mRole < 2 || mRole > 4)
         mAbove = 0;
      else if (loadShareLevel >= mEn[mRole - 2])
         mAbove = 1;
      else if (loadShareLevel < mDis[mRole - 2])
         mAbove = 0;
      e = mRole < 2 ? 0 : mRole == 5 ? mWake : (mWake && !mAbove);
      chk(n, 32'(converterOnN), 32'(e));
   endtask

   task automatic wrRole(input int r);
      axiWr(OFS_ROLE, 32'(r), RESP_OKAY);
      mRole = r;
      mAbove = 0;
      step("convRole");
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      close_out();
   end

   initial
   begin
      void'($urandom(32'h4afc_b999));
      for (int i = 0; i < 3; i++)
      begin
         mEn[i] = mvEn[i] * LS_FULL_CODE / LS_FULL_MV;
         mDis[i] = mvDis[i] * LS_FULL_CODE / LS_FULL_MV;
      end
      repeat (10) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      chk("convReset", 32'(converterOnN), 32'h0000_0000);
      for (int i = 0; i < 3; i++)
         rdChk("thrReset", 8'(OFS_POS1 + 4 * i), 32'(mEn[i] | (mDis[i] << 16)), RESP_OKAY);
      rdChk("roleReset", OFS_ROLE, 32'h0000_0000, RESP_OKAY);
      rdChk("unmapped", 8'h20, 32'h0000_0000, RESP_SLVERR);
      axiWr(8'h24, 32'h0000_0001, RESP_SLVERR);
      for (int r = 0; r < 2; r++)
      begin
         wrRole(r);
         chk("wakeDrive", 32'({wakeLineOe, wakeLineOut}), r ? 32'h0000_0003 : 32'h0000_0000);
         supplyFault <= r[0];
         outputUndervolt <= !r[0];
         step("convFault");
         chk("wakeFault", 32'({wakeLineOe, wakeLineOut}), 32'h0000_0002);
         supplyFault <= 1'h0;
         outputUndervolt <= 1'h0;
      end
      peerMode <= 2'h1;
      for (int p = 0; p < 3; p++)
      begin
         wrRole(p + 2);
         lv = '{mDis[p] - 1, mEn[p] - 1, mEn[p], (mEn[p] + mDis[p]) / 2, mDis[p], mDis[p] - 1};
         foreach (lv[j])
         begin
            loadShareLevel <= LEVEL_W'(lv[j]);
            step("convLevel");
         end
         repeat (4)
         begin
            loadShareLevel <= LEVEL_W'($urandom_range(LS_FULL_CODE));
            step("convRandom");
         end
      end
      wrRole(5);
      loadShareLevel <= LEVEL_W'(LS_FULL_CODE);
      step("convAlways");
      peerMode <= 2'h2;
      step("convWake");
      rdChk("roleRevert", OFS_ROLE, 32'h0000_0000, RESP_OKAY);
      axiRd(OFS_STATUS);
      chk("revertFlag", 32'(d[ST_REVERTED]), 32'h0000_0001);
      axiWr(OFS_STATUS, 32'h0000_0020, RESP_OKAY);
      axiRd(OFS_STATUS);
      chk("revertClear", 32'(d[ST_REVERTED]), 32'h0000_0000);
      peerMode <= 2'h0;
      step("convNoActive");
      wrRole(2);
      loadShareLevel <= '0;
      step("convNoActive");
      peerMode <= 2'h1;
      step("convStandby");
      axiRd(OFS_STATUS);
      chk("statusStandby", d, 32'h0000_0012);
      peerMode <= 2'h2;
      @(negedge wakeLineIn);
      repeat (3) @(posedge clk);
      #1;
      chk("wakeResp", 32'(converterOnN), 32'h0000_0000);
      step("convRevert");
      v = 200 + $urandom_range(2000);
      axiWr(OFS_POS1, 32'((v + 1) | ((v / 2) << 16)), RESP_OKAY);
      mEn[0] = v;
      mDis[0] = v / 2;
      rdChk("thrProg", OFS_POS1, 32'((v + 1) | ((v / 2) << 16)), RESP_OKAY);
      s_axi_wstrb <= 4'h3;
      axiWr(OFS_POS1, 32'h0fff_0000 | 32'(v), RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rdChk("thrStrobe", OFS_POS1, 32'(v | ((v / 2) << 16)), RESP_OKAY);
      axiWr(OFS_ROLE, 32'h0000_0007, RESP_OKAY);
      rdChk("roleBad", OFS_ROLE, 32'h0000_0000, RESP_OKAY);
      peerMode <= 2'h1;
      step("convIdle");
      wrRole(2);
      loadShareLevel <= LEVEL_W'(v - 1);
      step("convProgLow");
      loadShareLevel <= LEVEL_W'(v);
      step("convProgHigh");
      close_out();
   end
endmodule

`default_nettype wire
